// ==== logic/ict_pkg.sv ====
// Purpose: Shared constants and types for the instruction cycle timing core.
// Assumes: One system clock; one instruction cycle is four clock periods.
// Notes: The opcode encoding is local to this core and its program memory image.

package ict_pkg;

   // ****************************************
   // Instruction cycle phases
   // ****************************************
   localparam int PH_W = 2;
   localparam logic [PH_W-1:0] PH_FETCH = 2'h0;
   localparam logic [PH_W-1:0] PH_DECODE = 2'h1;
   localparam logic [PH_W-1:0] PH_READ = 2'h2;
   localparam logic [PH_W-1:0] PH_EXEC = 2'h3;

   // ****************************************
   // Instruction word layout
   // ****************************************
   localparam int IW_W = 16;
   localparam int OPC_MSB = 15;
   localparam int OPC_LSB = 11;
   localparam int BIT_MSB = 10;
   localparam int BIT_LSB = 8;
   localparam int OPD_MSB = 7;
   localparam int OPD_LSB = 0;
   localparam int DATA_W = 8;

   // Data memory address whose writes, except the write that finishes a table read, go to the low byte of the program counter instead of memory.
   localparam logic [DATA_W-1:0] PC_LOW_ADDR = 8'h06;

   // ****************************************
   // Defaults
   // ****************************************
   localparam int PC_W_DEF = 11;
   localparam int STACK_DEPTH_DEF = 8;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;

   typedef enum logic [4:0] {
      op_nop,
      op_mov_a_m,
      op_mov_m_a,
      op_mov_a_x,
      op_add_a_m,
      op_sub_a_m,
      op_and_a_m,
      op_or_a_m,
      op_xor_a_m,
      complement_op,
      op_increment_mem,
      increment_to_acc_op,
      decrement_mem_op,
      decrement_to_acc_op,
      rotate_right_op,
      rotate_left_op,
      rotate_right_carry_op,
      rotate_left_carry_op,
      op_bit_set,
      bit_clear_op,
      op_skip_zero,
      op_skip_nonzero,
      op_skip_bit_zero,
      op_skip_bit_nonzero,
      jump_op,
      op_call,
      subroutine_return_op,
      interrupt_return_op,
      op_table_read
   } ict_op_t;

   typedef enum logic {
      st_exec,
      st_extra
   } ict_state_t;

endpackage

// ==== logic/ict_core.sv ====
// Purpose: Sequences an 8-bit core in four-phase instruction cycles and executes its instructions.
// Assumes: Program memory returns the word for pmem_addr_o one clock later; data memory answers within the same clock.
// Notes: Two-cycle instructions spend a second instruction cycle in st_extra, which is idle except to finish a table read.

module ict_core
   import ict_pkg::*;
#(
   parameter int PC_W = PC_W_DEF,
   parameter int STACK_DEPTH = STACK_DEPTH_DEF
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   output logic [PC_W-1:0] pmem_addr_o,
   input wire logic [IW_W-1:0] pmem_data_i,
   output logic [DATA_W-1:0] dmem_addr_o,
   output logic [DATA_W-1:0] dmem_wdata_o,
   output logic dmem_we_o,
   input wire logic [DATA_W-1:0] dmem_rdata_i,
   output logic [DATA_W-1:0] acc_o,
   output logic zero_flag_o,
   output logic carry_flag_o,
   output logic [PH_W-1:0] phase_o,
   output logic cycle_start_o,
   output logic extra_cycle_o
);
   localparam int SP_W = $clog2(STACK_DEPTH);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] sel);
      bit_mask = 8'h01 << sel;
   endfunction
   function automatic logic is_zero(input logic [DATA_W-1:0] v);
      is_zero = (v == 8'h00);
   endfunction
   // ****************************************
   // State
   // ****************************************
   logic [PH_W-1:0] phase, next_phase;
   ict_state_t state, next_state;
   logic [PC_W-1:0] pc, next_pc;
   logic [PC_W-1:0] fetch_addr, next_fetch_addr;
   logic [IW_W-1:0] ir, next_ir;
   logic [DATA_W-1:0] mdata, next_mdata;
   logic [DATA_W-1:0] tbl_data, next_tbl_data;
   logic [DATA_W-1:0] acc, next_acc;
   logic zflag, next_zflag;
   logic cflag, next_cflag;
   logic [DATA_W-1:0] daddr, next_daddr;
   logic [DATA_W-1:0] wdata, next_wdata;
   logic we, next_we;
   logic cstart, next_cstart;
   logic [SP_W-1:0] sp, next_sp;
   logic push_en;
   logic [PC_W-1:0] push_data;
   logic [PC_W-1:0] stack [STACK_DEPTH];
   ict_op_t op;
   logic [2:0] bsel;
   logic [DATA_W-1:0] opd;
   logic [PC_W-1:0] pc_inc;
   logic [PC_W-1:0] npc;
   logic [DATA_W-1:0] res;
   logic [DATA_W:0] wide;
   logic wr, two, skip;
   assign op = ict_op_t'(ir[OPC_MSB:OPC_LSB]);
   assign bsel = ir[BIT_MSB:BIT_LSB];
   assign opd = ir[OPD_MSB:OPD_LSB];
   assign pc_inc = pc + PC_W'(1);
   always_comb begin
      next_phase = phase + PH_W'(1);
      next_state = state;
      next_pc = pc;
      next_fetch_addr = fetch_addr;
      next_ir = ir;
      next_mdata = mdata;
      next_tbl_data = tbl_data;
      next_acc = acc;
      next_zflag = zflag;
      next_cflag = cflag;
      next_daddr = daddr;
      next_wdata = wdata;
      next_we = 1'b0;
      next_cstart = (phase == PH_EXEC);
      next_sp = sp;
      push_en = 1'b0;
      push_data = pc_inc;
      npc = pc_inc;
      res = mdata;
      wide = '0;
      wr = 1'b0;
      two = 1'b0;
      skip = 1'b0;
      if (phase == PH_DECODE && state == st_exec) begin
         next_ir = pmem_data_i;
         next_daddr = pmem_data_i[OPD_MSB:OPD_LSB];
      end
      if (phase == PH_DECODE && state == st_extra) begin
         next_tbl_data = pmem_data_i[DATA_W-1:0];
      end
      if (phase == PH_READ) begin
         next_mdata = dmem_rdata_i;
      end
      if (phase == PH_EXEC && state == st_extra) begin
         // The second cycle only finishes a table read and fetches at the new pc.
         next_state = st_exec;
         next_fetch_addr = pc;
         if (op == op_table_read) begin
            next_wdata = tbl_data;
            next_we = 1'b1;
         end
      end else if (phase == PH_EXEC) begin
         unique case (op)
            op_nop: ;
            op_mov_a_m: next_acc = mdata;
            op_mov_m_a: begin
               res = acc;
               wr = 1'b1;
            end
            op_mov_a_x: next_acc = opd;
            op_add_a_m: begin
               wide = {1'b0, acc} + {1'b0, mdata};
               next_acc = wide[DATA_W-1:0];
               next_cflag = wide[DATA_W];
               next_zflag = is_zero(wide[DATA_W-1:0]);
            end
            op_sub_a_m: begin
               wide = {1'b0, acc} - {1'b0, mdata};
               next_acc = wide[DATA_W-1:0];
               next_cflag = wide[DATA_W];
               next_zflag = is_zero(wide[DATA_W-1:0]);
            end
            op_and_a_m: begin
               next_acc = acc & mdata;
               next_zflag = is_zero(acc & mdata);
            end
            op_or_a_m: begin
               next_acc = acc | mdata;
               next_zflag = is_zero(acc | mdata);
            end
            op_xor_a_m: begin
               next_acc = acc ^ mdata;
               next_zflag = is_zero(acc ^ mdata);
            end
            complement_op: begin
               res = ~mdata;
               wr = 1'b1;
               next_zflag = is_zero(~mdata);
            end
            op_increment_mem: begin
               res = mdata + 8'h01;
               wr = 1'b1;
               next_zflag = is_zero(res);
            end
            increment_to_acc_op: begin
               next_acc = mdata + 8'h01;
               next_zflag = is_zero(next_acc);
            end
            decrement_mem_op: begin
               res = mdata - 8'h01;
               wr = 1'b1;
               next_zflag = is_zero(res);
            end
            decrement_to_acc_op: begin
               next_acc = mdata - 8'h01;
               next_zflag = is_zero(next_acc);
            end
            rotate_right_op: begin
               res = {mdata[0], mdata[DATA_W-1:1]};
               wr = 1'b1;
            end
            rotate_left_op: begin
               res = {mdata[DATA_W-2:0], mdata[DATA_W-1]};
               wr = 1'b1;
            end
            rotate_right_carry_op: begin
               res = {cflag, mdata[DATA_W-1:1]};
               next_cflag = mdata[0];
               wr = 1'b1;
            end
            rotate_left_carry_op: begin
               res = {mdata[DATA_W-2:0], cflag};
               next_cflag = mdata[DATA_W-1];
               wr = 1'b1;
            end
            op_bit_set: begin
               res = mdata | bit_mask(bsel);
               wr = 1'b1;
            end
            bit_clear_op: begin
               res = mdata & ~bit_mask(bsel);
               wr = 1'b1;
            end
            op_skip_zero: skip = is_zero(mdata);
            op_skip_nonzero: skip = !is_zero(mdata);
            op_skip_bit_zero: skip = !mdata[bsel];
            op_skip_bit_nonzero: skip = mdata[bsel];
            jump_op: begin
               npc = ir[PC_W-1:0];
               two = 1'b1;
            end
            op_call: begin
               push_en = 1'b1;
               next_sp = sp + SP_W'(1);
               npc = ir[PC_W-1:0];
               two = 1'b1;
            end
            subroutine_return_op, interrupt_return_op: begin
               npc = stack[sp - SP_W'(1)];
               next_sp = sp - SP_W'(1);
               two = 1'b1;
            end
            op_table_read: two = 1'b1;
            default: ;
         endcase
         if (skip) begin
            npc = pc + PC_W'(2);
            two = 1'b1;
         end
         if (wr && daddr == PC_LOW_ADDR) begin
            npc = {pc[PC_W-1:DATA_W], res};
            two = 1'b1;
         end else if (wr) begin
            next_wdata = res;
            next_we = 1'b1;
         end
         next_pc = npc;
         next_state = two ? st_extra : st_exec;
         next_fetch_addr = (op == op_table_read) ? PC_W'({acc}) : npc;
      end
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase <= PH_FETCH;
         state <= st_exec;
         pc <= '0;
         fetch_addr <= '0;
         ir <= '0;
         mdata <= '0;
         tbl_data <= '0;
         acc <= ACC_RST;
         zflag <= 1'b0;
         cflag <= 1'b0;
         daddr <= '0;
         wdata <= '0;
         we <= 1'b0;
         cstart <= 1'b1;
         sp <= '0;
      end else begin
         phase <= next_phase;
         state <= next_state;
         pc <= next_pc;
         fetch_addr <= next_fetch_addr;
         ir <= next_ir;
         mdata <= next_mdata;
         tbl_data <= next_tbl_data;
         acc <= next_acc;
         zflag <= next_zflag;
         cflag <= next_cflag;
         daddr <= next_daddr;
         wdata <= next_wdata;
         we <= next_we;
         cstart <= next_cstart;
         sp <= next_sp;
      end
   end
   // Return stack storage; it holds data only, so it needs no reset.
   always_ff @(posedge ref_clk_i) begin
      if (push_en) begin
         stack[sp] <= push_data;
      end
   end
   assign pmem_addr_o = fetch_addr;
   assign dmem_addr_o = daddr;
   assign dmem_wdata_o = wdata;
   assign dmem_we_o = we;
   assign acc_o = acc;
   assign zero_flag_o = zflag;
   assign carry_flag_o = cflag;
   assign phase_o = phase;
   assign cycle_start_o = cstart;
   assign extra_cycle_o = (state == st_extra);
endmodule // ict_core

// ==== tb/ict_core_monitor.sv ====
// Purpose: Concurrent checks on the ports of the instruction cycle timing core.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Attached to every core instance by the bind at the foot of this file.
module ict_core_monitor
   import ict_pkg::*;
#(
   parameter int PC_W = PC_W_DEF
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [PC_W-1:0] pmem_addr_o,
   input wire logic [IW_W-1:0] pmem_data_i,
   input wire logic [DATA_W-1:0] dmem_addr_o,
   input wire logic [DATA_W-1:0] dmem_wdata_o,
   input wire logic dmem_we_o,
   input wire logic [DATA_W-1:0] dmem_rdata_i,
   input wire logic [DATA_W-1:0] acc_o,
   input wire logic zero_flag_o,
   input wire logic carry_flag_o,
   input wire logic [PH_W-1:0] phase_o,
   input wire logic cycle_start_o,
   input wire logic extra_cycle_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Jump target as decoded, kept until the result shows.
   logic [PC_W-1:0] tgt;
   always_ff @(posedge ref_clk_i) begin
      if (phase_o == PH_DECODE) begin
         tgt <= pmem_data_i[PC_W-1:0];
      end
   end
   sequence s_four_phases;
      phase_o == PH_FETCH ##1 phase_o == PH_DECODE ##1 phase_o == PH_READ ##1 phase_o == PH_EXEC;
   endsequence
   sequence s_extra_run;
      (extra_cycle_o && cycle_start_o) ##1 extra_cycle_o [*3] ##1 !extra_cycle_o;
   endsequence
   property p_four_phases;
      phase_o == PH_EXEC |=> s_four_phases;
   endproperty
   a_four_phases: assert property (p_four_phases) else $error("phase order broken");
   property p_start;
      cycle_start_o == (phase_o == PH_FETCH);
   endproperty
   a_start: assert property (p_start) else $error("cycle start misplaced");
   property p_pc_hold;
      phase_o != PH_EXEC |=> $stable(pmem_addr_o);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("fetch address moved mid cycle");
   property p_res_hold;
      phase_o != PH_EXEC |=> $stable(acc_o) && $stable(zero_flag_o) && $stable(carry_flag_o);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result moved mid cycle");
   property p_we_pulse;
      dmem_we_o |-> phase_o == PH_FETCH ##1 !dmem_we_o;
   endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("write strobe misplaced");
   property p_extra_len;
      $rose(extra_cycle_o) |-> s_extra_run;
   endproperty
   a_extra_len: assert property (p_extra_len) else $error("extra cycle length wrong");
   property p_no_pcl_wr;
      dmem_we_o |-> dmem_addr_o != PC_LOW_ADDR;
   endproperty
   a_no_pcl_wr: assert property (p_no_pcl_wr) else $error("pc low written to memory");
   property p_pc_next;
      phase_o == PH_EXEC && !extra_cycle_o |=>
         extra_cycle_o || pmem_addr_o == PC_W'($past(pmem_addr_o) + 1);
   endproperty
   a_pc_next: assert property (p_pc_next) else $error("one cycle step not pc plus one");
   property p_jump;
      phase_o == PH_DECODE && !extra_cycle_o && pmem_data_i[OPC_MSB:OPC_LSB] == jump_op |->
         ##3 extra_cycle_o && pmem_addr_o == tgt;
   endproperty
   a_jump: assert property (p_jump) else $error("jump target or timing wrong");
   property p_phase_restart;
      $rose(rst_n_i) |-> phase_o == PH_FETCH && !extra_cycle_o;
   endproperty
   a_phase_restart: assert property (p_phase_restart) else $error("no phase restart");
endmodule // ict_core_monitor

bind ict_core ict_core_monitor #(.PC_W(PC_W)) mon_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
   .pmem_addr_o(pmem_addr_o), .pmem_data_i(pmem_data_i), .dmem_addr_o(dmem_addr_o),
   .dmem_wdata_o(dmem_wdata_o), .dmem_we_o(dmem_we_o), .dmem_rdata_i(dmem_rdata_i),
   .acc_o(acc_o), .zero_flag_o(zero_flag_o), .carry_flag_o(carry_flag_o), .phase_o(phase_o),
   .cycle_start_o(cycle_start_o), .extra_cycle_o(extra_cycle_o));

// ==== tb/ict_mem_model.sv ====
// Purpose: Program and data memory on the far side of the core.
// Assumes: Contents are loaded by the bench while the core is held in reset.
// Notes: Program words come one clock after the address; data reads settle within the clock.
module ict_mem_model
   import ict_pkg::*;
#(
   parameter int PC_W = PC_W_DEF
) (
   input wire logic ref_clk_i,
   input wire logic [PC_W-1:0] pmem_addr_i,
   output logic [IW_W-1:0] pmem_data_o,
   input wire logic [DATA_W-1:0] dmem_addr_i,
   input wire logic [DATA_W-1:0] dmem_wdata_i,
   input wire logic dmem_we_i,
   output logic [DATA_W-1:0] dmem_rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [IW_W-1:0] pword [0:(1<<PC_W)-1];
   logic [DATA_W-1:0] dbyte [0:255];
   assign dmem_rdata_o = dbyte[dmem_addr_i];
   always @(posedge ref_clk_i) begin
      pmem_data_o <= pword[pmem_addr_i];
      if (dmem_we_i) begin
         dbyte[dmem_addr_i] <= dmem_wdata_i;
      end
   end
endmodule // ict_mem_model

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the instruction cycle timing core.
// Assumes: Core and memory model share one 20 MHz clock.
// Notes: Each scenario loads a short program, resets the core and judges the result.
module tb
   import ict_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] NOP_W = 16'h0000;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [10:0] pa;
   logic [15:0] pd;
   logic [7:0] da;
   logic [7:0] dw;
   logic [7:0] dr;
   logic [7:0] acc;
   logic dwe;
   logic zf;
   logic cf;
   logic cs;
   logic xc;
   int n_errors = 0;
   int checks_done = 0;
   int n_extra = 0;
   ict_core #(.PC_W(11), .STACK_DEPTH(8)) dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .pmem_addr_o(pa), .pmem_data_i(pd), .dmem_addr_o(da), .dmem_wdata_o(dw), .dmem_we_o(dwe),
      .dmem_rdata_i(dr), .acc_o(acc), .zero_flag_o(zf), .carry_flag_o(cf), .phase_o(),
      .cycle_start_o(cs), .extra_cycle_o(xc));
   ict_mem_model #(.PC_W(11)) mem_u (.ref_clk_i(ref_clk_i), .pmem_addr_i(pa), .pmem_data_o(pd),
      .dmem_addr_i(da), .dmem_wdata_i(dw), .dmem_we_i(dwe), .dmem_rdata_o(dr));
   initial begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // Counts the second cycles of two-cycle instructions since reset.
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) n_extra <= 0;
      else if (cs === 1'b1 && xc === 1'b1) n_extra <= n_extra + 1;
   end
   function automatic logic [15:0] iw(input ict_op_t op, input int b, input int m);
      return {op, 3'(b), 8'(m)};
   endfunction
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic load_run(input logic [15:0] w0, w1, w2, w3);
      logic [7:0] init [10] = '{8'hff, 8'h01, 8'h00, 8'h7f, 8'h81, 8'h40, 8'h01, 8'hff, 8'h00,
         8'h00};
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      for (int i = 0; i < 256; i++) mem_u.dbyte[i] = (i >= 16 && i < 26) ? init[i-16] : 8'h00;
      for (int i = 0; i < 32; i++) mem_u.pword[i] = NOP_W;
      mem_u.pword[0] = w0;
      mem_u.pword[1] = w1;
      mem_u.pword[2] = w2;
      mem_u.pword[3] = w3;
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (60) @(posedge ref_clk_i);
      #5;
   endtask
   task automatic t_arith;
      load_run(iw(op_mov_a_m, 0, 8'h10), iw(op_add_a_m, 0, 8'h11), NOP_W, NOP_W);
      chk8("add acc", 8'h00, acc);
      chk8("add carry", 8'h01, {7'h00, cf});
      load_run(iw(op_sub_a_m, 0, 8'h11), NOP_W, NOP_W, NOP_W);
      chk8("sub acc", 8'hff, acc);
      chk8("sub borrow", 8'h01, {7'h00, cf});
      $display("arith test done");
   endtask
   task automatic t_logic_incdec;
      load_run(iw(op_mov_a_m, 0, 8'h10), iw(op_and_a_m, 0, 8'h12), iw(op_or_a_m, 0, 8'h10),
         iw(op_xor_a_m, 0, 8'h10));
      chk8("xor zero", 8'h01, {7'h00, zf});
      load_run(iw(complement_op, 0, 8'h17), NOP_W, NOP_W, NOP_W);
      chk8("complement zero", 8'h01, {7'h00, zf});
      load_run(iw(decrement_to_acc_op, 0, 8'h12), iw(op_increment_mem, 0, 8'h11),
         iw(decrement_mem_op, 0, 8'h10), iw(increment_to_acc_op, 0, 8'h13));
      chk8("inc acc", 8'h80, acc);
      chk8("inc mem", 8'h02, mem_u.dbyte[8'h11]);
      chk8("decrement mem", 8'hfe, mem_u.dbyte[8'h10]);
      $display("logic and step test done");
   endtask
   task automatic t_rot_bits;
      load_run(iw(rotate_left_op, 0, 8'h14), iw(rotate_right_carry_op, 0, 8'h14),
         iw(rotate_left_carry_op, 0, 8'h15), iw(rotate_right_op, 0, 8'h16));
      chk8("rotate right carry mem", 8'h01, mem_u.dbyte[8'h14]);
      chk8("rotate left carry mem", 8'h81, mem_u.dbyte[8'h15]);
      chk8("rotate right mem", 8'h80, mem_u.dbyte[8'h16]);
      chk8("rotate carry out", 8'h00, {7'h00, cf});
      load_run(iw(op_bit_set, 3'h3, 8'h18), iw(bit_clear_op, 3'h7, 8'h17), NOP_W, NOP_W);
      chk8("set bit", 8'h08, mem_u.dbyte[8'h18]);
      chk8("clear bit", 8'h7f, mem_u.dbyte[8'h17]);
      $display("rotate and bit test done");
   endtask
   task automatic t_branch;
      load_run(iw(jump_op, 0, 8'h03), iw(increment_to_acc_op, 0, 8'h10), NOP_W,
         iw(op_mov_a_m, 0, 8'h13));
      chk8("jump acc", 8'h7f, acc);
      chk8("jump cycles", 8'h01, 8'(n_extra));
      for (int k = 0; k < 2; k++) begin
         load_run(iw(op_call, 0, 8'h03), iw(increment_to_acc_op, 0, 8'h13), iw(jump_op, 0, 8'h02),
            iw(ict_op_t'(k == 0 ? subroutine_return_op : interrupt_return_op), 0, 0));
         chk8("return acc", 8'h80, acc);
      end
      load_run(iw(op_mov_a_x, 0, 8'h03), iw(op_mov_m_a, 0, PC_LOW_ADDR),
         iw(increment_to_acc_op, 0, 8'h10), NOP_W);
      chk8("pc low acc", 8'h03, acc);
      chk8("pc low cycles", 8'h01, 8'(n_extra));
      // Word 3 is the table entry; its zero opcode also makes it a no-op when executed.
      load_run(iw(op_mov_a_x, 0, 8'h03), iw(op_table_read, 0, 8'h19), NOP_W, 16'h00a5);
      chk8("table mem", 8'ha5, mem_u.dbyte[8'h19]);
      chk8("table cycles", 8'h01, 8'(n_extra));
      $display("branch test done");
   endtask
   task automatic t_skip;
      ict_op_t sk [4] = '{op_skip_zero, op_skip_nonzero, op_skip_bit_zero, op_skip_bit_nonzero};
      logic [7:0] ea [4] = '{8'h00, 8'h7f, 8'h7f, 8'h00};
      for (int k = 0; k < 4; k++) begin
         load_run(iw(sk[k], 0, k < 2 ? 8'h12 : 8'h13), iw(op_mov_a_m, 0, 8'h10),
            iw(op_and_a_m, 0, 8'h13), NOP_W);
         chk8("skip acc", ea[k], acc);
         chk8("skip cycles", ea[k] == 0 ? 8'h01 : 8'h00, 8'(n_extra));
      end
      $display("skip test done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      n_errors++;
      finish_test;
   end
   initial begin
      t_arith;
      t_logic_incdec;
      t_rot_bits;
      t_branch;
      t_skip;
      finish_test;
   end
endmodule // tb
